// file: logic/pulse_gen_bandwidth_cal.sv
// pulse generator calibration: count, auto-calibration, test and target registers
//
// Register access over Avalon-MM was chosen for this implementation.
`timescale 1ns/10ps
`include "pulse_cal_regs.svh"

// Behaviour
// - count increments once per generator pulse during the measurement window
// - status bits 11..0 report the last count measurement, or the best search count after auto-calibration, read only
// - larger spacing delay gives fewer pulses; search steps delay accordingly
// - auto-calibration searches a spacing delay giving the requested count
// - on completion delay goes to transmit control, done bit 12 set
// - finish at target; keep the achievable count nearest the target
// - test register 0x0000 normal, 0x000F continuous-wave
// - auto start bit 1 set by software, cleared by device at completion
// - count start bit 0 measures at current delay, self-clears when done
// - control bits 5..2 are the top four bits of a 10-bit window counter
module pulse_gen_bandwidth_cal
	import pulse_cal_pkg::*;
(
	// clock and reset
	input  wire logic        sys_clk_in,
	input  wire logic        arst_n_in,
	// avalon-mm slave
	input  wire logic [7:0]  avs_address_in,
	input  wire logic        avs_read_in,
	input  wire logic        avs_write_in,
	input  wire logic [31:0] avs_writedata_in,
	input  wire logic [3:0]  avs_byteenable_in,
	output logic [31:0]      avs_readdata_out,
	output logic             avs_waitrequest_out,
	// pulse generator
	input  wire logic        pulse_in,
	output logic [7:0]       pulse_spacing_delay_out,
	output logic             cw_mode_out,
	// interrupt
	output logic             irq_out
);
	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	logic [15:0]             ctrl_r;
	logic [15:0]             test_r;
	logic [15:0]             target_r;
	logic [`COUNT_W-1:0]     count_r;
	logic                    done_r;
	logic [`DELAY_W-1:0]     delay_r;
	logic [1:0]              irq_stat_r;
	logic [1:0]              irq_mask_r;
	logic [31:0]             rdata_r;
	logic                    ack_r;
	cal_state_e              state_r;
	logic                    auto_r;
	logic [`WIN_CNT_W-1:0]   win_r;
	logic [`COUNT_W-1:0]     meas_r;
	logic [`DELAY_W-1:0]     try_r;
	logic [`DELAY_W-1:0]     step_r;
	logic [`DELAY_W-1:0]     best_delay_r;
	logic [`COUNT_W-1:0]     best_count_r;
	logic [`COUNT_W:0]       best_err_r;
	logic                    pulse_rise;
	logic                    wr_acc;
	logic                    rd_acc;
	logic                    ev_count_done;
	logic                    ev_auto_done;
	logic [`COUNT_W-1:0]     target_cnt;
	logic [`COUNT_W:0]       err_nxt;
	logic [`WIN_CNT_W-1:0]   win_len;

	pulse_sync3 u_sync (
		.sys_clk_in (sys_clk_in),
		.arst_n_in  (arst_n_in),
		.async_in   (pulse_in),
		.level_out  (),
		.rise_out   (pulse_rise)
	);

	// ----------------------------------------------------------------
	// bus handshake: one wait cycle, then ack
	// ----------------------------------------------------------------
	assign avs_waitrequest_out = (avs_read_in || avs_write_in) && !ack_r;
	// write lands at the edge where waitrequest is low, not before
	assign wr_acc = avs_write_in && ack_r;
	// read data loaded one edge early so it stands when waitrequest drops
	assign rd_acc = avs_read_in && !ack_r;

	always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			ack_r <= 1'b0;
		end else begin
			ack_r <= (avs_read_in || avs_write_in) && !ack_r;
		end
	end

	always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			rdata_r <= 32'h0;
		end else if (rd_acc) begin
			case (avs_address_in)
				`CTRL_OFFSET:     rdata_r <= {16'h0, ctrl_r};
				`STATUS_OFFSET:   rdata_r <= {19'h0, done_r, count_r};
				`TEST_OFFSET:     rdata_r <= {16'h0, test_r};
				`TARGET_OFFSET:   rdata_r <= {16'h0, target_r};
				`TXCTRL_OFFSET:   rdata_r <= {24'h0, delay_r};
				`IRQ_STAT_OFFSET: rdata_r <= {30'h0, irq_stat_r};
				`IRQ_MASK_OFFSET: rdata_r <= {30'h0, irq_mask_r};
				default:          rdata_r <= 32'h0;
			endcase
		end
	end
	assign avs_readdata_out = rdata_r;

	// ----------------------------------------------------------------
	// control register with self-clearing start bits
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			ctrl_r <= `CTRL_RESET;
		end else if (wr_acc && avs_address_in == `CTRL_OFFSET && avs_byteenable_in[0]) begin
			ctrl_r[7:0] <= avs_writedata_in[7:0];
		end else begin
			if (ev_count_done) begin
				ctrl_r[`CTRL_COUNT_BIT] <= 1'b0;
			end
			if (ev_auto_done) begin
				ctrl_r[`CTRL_AUTO_BIT] <= 1'b0;
			end
		end
	end

	always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			test_r <= `TEST_RESET;
		end else if (wr_acc && avs_address_in == `TEST_OFFSET) begin
			if (avs_byteenable_in[0]) test_r[7:0] <= avs_writedata_in[7:0];
			if (avs_byteenable_in[1]) test_r[15:8] <= avs_writedata_in[15:8];
		end
	end
	assign cw_mode_out = (test_r == `TEST_CW_VALUE);

	// target writable in its 12 used bits; reserved bits held
	always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			target_r <= `TARGET_RESET;
		end else if (wr_acc && avs_address_in == `TARGET_OFFSET) begin
			if (avs_byteenable_in[0]) target_r[7:0] <= avs_writedata_in[7:0];
			if (avs_byteenable_in[1]) target_r[11:8] <= avs_writedata_in[11:8];
		end
	end
	assign target_cnt = target_r[`COUNT_W-1:0];

	always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			irq_mask_r <= 2'h0;
		end else if (wr_acc && avs_address_in == `IRQ_MASK_OFFSET && avs_byteenable_in[0]) begin
			irq_mask_r <= avs_writedata_in[1:0];
		end
	end

	// set wins over write-one-to-clear
	always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			irq_stat_r <= 2'h0;
		end else begin
			irq_stat_r <= (irq_stat_r & ~((wr_acc && avs_address_in == `IRQ_STAT_OFFSET
				&& avs_byteenable_in[0]) ? avs_writedata_in[1:0] : 2'h0))
				| {ev_auto_done, ev_count_done};
		end
	end
	assign irq_out = |(irq_stat_r & irq_mask_r);

	// ----------------------------------------------------------------
	// transmit control delay and status
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			delay_r <= `DELAY_RESET;
		end else if (ev_auto_done) begin
			delay_r <= best_delay_r;
		end else if (wr_acc && avs_address_in == `TXCTRL_OFFSET && avs_byteenable_in[0]) begin
			delay_r <= avs_writedata_in[7:0];
		end
	end
	assign pulse_spacing_delay_out = (state_r == ST_IDLE) ? delay_r : try_r;

	always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			done_r <= 1'b0;
		end else if (ev_auto_done) begin
			done_r <= 1'b1;
		end else if (state_r == ST_IDLE && ctrl_r[`CTRL_AUTO_BIT]) begin
			done_r <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			count_r <= '0;
		end else if (ev_count_done) begin
			count_r <= meas_r;
		end else if (ev_auto_done) begin
			count_r <= best_count_r;
		end
	end

	// ----------------------------------------------------------------
	// measurement and search sequencer
	// ----------------------------------------------------------------
	assign win_len = {ctrl_r[`CTRL_WIN_MSB:`CTRL_WIN_LSB], {`WIN_LOW_W{1'b1}}};
	assign err_nxt = (meas_r >= target_cnt) ? {1'b0, meas_r - target_cnt}
		: {1'b0, target_cnt - meas_r};
	assign ev_count_done = (state_r == ST_DECIDE) && !auto_r;
	assign ev_auto_done  = (state_r == ST_FINISH);

	always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			state_r      <= ST_IDLE;
			auto_r       <= 1'b0;
			win_r        <= '0;
			meas_r       <= '0;
			try_r        <= '0;
			step_r       <= '0;
			best_delay_r <= '0;
			best_count_r <= '0;
			best_err_r   <= '0;
		end else begin
			case (state_r)
				ST_IDLE: begin
					try_r <= delay_r;
					if (ctrl_r[`CTRL_AUTO_BIT]) begin
						auto_r       <= 1'b1;
						try_r        <= 8'h80;
						step_r       <= 8'h40;
						best_err_r   <= {1'b1, 12'hFFF};
						state_r      <= ST_ARM;
					end else if (ctrl_r[`CTRL_COUNT_BIT]) begin
						auto_r  <= 1'b0;
						state_r <= ST_ARM;
					end
				end
				ST_ARM: begin
					win_r   <= win_len;
					meas_r  <= '0;
					state_r <= ST_MEASURE;
				end
				ST_MEASURE: begin
					if (pulse_rise && meas_r != 12'hFFF) begin
						meas_r <= meas_r + 12'h1;
					end
					if (win_r == '0) begin
						state_r <= ST_DECIDE;
					end else begin
						win_r <= win_r - 10'h1;
					end
				end
				ST_DECIDE: begin
					if (!auto_r) begin
						state_r <= ST_IDLE;
					end else begin
						if (err_nxt < best_err_r) begin
							best_err_r   <= err_nxt;
							best_delay_r <= try_r;
							best_count_r <= meas_r;
						end
						// stop on an exact match or once the step has run out
						if (err_nxt == '0 || step_r == '0) begin
							state_r <= ST_FINISH;
						end else begin
							// too many pulses means spacing too short
							if (meas_r > target_cnt) begin
								try_r <= try_r + step_r;
							end else begin
								try_r <= try_r - step_r;
							end
							step_r  <= step_r >> 1;
							state_r <= ST_ARM;
						end
					end
				end
				ST_FINISH: begin
					auto_r  <= 1'b0;
					state_r <= ST_IDLE;
				end
				default: state_r <= ST_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	AST_DONE_SETS: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
		ev_auto_done |=> done_r && delay_r == $past(best_delay_r))
		else $error("done flag or delay not updated on completion");
	AST_AUTO_CLEARS: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
		ev_auto_done && !wr_acc |=> !ctrl_r[`CTRL_AUTO_BIT])
		else $error("auto start bit not cleared");
	AST_COUNT_CLEARS: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
		ev_count_done && !wr_acc |=> !ctrl_r[`CTRL_COUNT_BIT] && count_r == $past(meas_r))
		else $error("count start not cleared or count not stored");
	AST_CW: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
		wr_acc && avs_address_in == 8'h18 && avs_byteenable_in[1:0] == 2'b11
		|=> cw_mode_out == ($past(avs_writedata_in[15:0]) == 16'h000F))
		else $error("cw mode mismatch");
	AST_PULSE_CNT: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
		state_r == ST_MEASURE && pulse_rise && meas_r != 12'hFFF |=> meas_r == $past(meas_r) + 12'h1)
		else $error("pulse not counted");
	AST_WINDOW: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
		state_r == ST_ARM |=> win_r == {ctrl_r[5:2], 6'h3F})
		else $error("window length wrong");
	AST_SEARCH_DIR: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
		state_r == ST_DECIDE && auto_r && err_nxt != '0 && step_r != '0 && meas_r > target_cnt
		|=> try_r == $past(try_r) + $past(step_r))
		else $error("delay not raised when count high");
	AST_DONE_CLR: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
		state_r == ST_IDLE && ctrl_r[1] |=> !done_r ##1 state_r == ST_MEASURE)
		else $error("done flag not cleared on restart");
	AST_STATUS_RD: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
		rd_acc && avs_address_in == 8'h14 |=> avs_readdata_out[31:13] == '0)
		else $error("status upper bits nonzero");
	AST_BEST: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
		ev_auto_done |=> count_r == $past(best_count_r))
		else $error("reported count not best");
	AST_SEARCH_DOWN: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
		state_r == ST_DECIDE && auto_r && err_nxt != '0 && step_r != '0 && meas_r < target_cnt
		|=> try_r == $past(try_r) - $past(step_r))
		else $error("delay not lowered when count low");
	AST_STEP_HALVES: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
		state_r == ST_DECIDE && auto_r && err_nxt != '0 && step_r != '0
		|=> step_r == ($past(step_r) >> 1))
		else $error("search step not halved");
	AST_COUNT_HOLD: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
		!ev_count_done && !ev_auto_done |=> $stable(count_r))
		else $error("reported count changed without a result");
	AST_IRQ_SET: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
		ev_count_done |=> irq_stat_r[0])
		else $error("count done event not latched");
	AST_FINISH_IDLE: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
		ev_auto_done |=> state_r == ST_IDLE && !auto_r)
		else $error("sequencer not idle after completion");
	AST_COUNT_START: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
		state_r == ST_IDLE && !ctrl_r[1] && ctrl_r[0]
		|=> state_r == ST_ARM && !auto_r && pulse_spacing_delay_out == $past(delay_r))
		else $error("count measurement not started at current delay");
endmodule

// file: logic/pulse_cal_regs.svh
// register map, field positions, reset values and timing for pulse calibration
`ifndef PULSE_CAL_REGS_SVH
`define PULSE_CAL_REGS_SVH

`define CTRL_OFFSET        8'h10
`define STATUS_OFFSET      8'h14
`define TEST_OFFSET        8'h18
`define TARGET_OFFSET      8'h1C
`define TXCTRL_OFFSET      8'h20
`define IRQ_STAT_OFFSET    8'h24
`define IRQ_MASK_OFFSET    8'h28

`define CTRL_COUNT_BIT     0
`define CTRL_AUTO_BIT      1
`define CTRL_WIN_LSB       2
`define CTRL_WIN_MSB       5
`define STATUS_DONE_BIT    12
`define COUNT_W            12
`define DELAY_W            8

`define CTRL_RESET         16'h0080
`define TEST_RESET         16'h0000
`define TEST_CW_VALUE      16'h000F
`define TARGET_RESET       16'h00A6
`define DELAY_RESET        8'h80
`define WIN_CNT_W          10
`define WIN_LOW_W          6
`define IRQ_COUNT_BIT      0
`define IRQ_AUTO_BIT       1

`endif

// file: logic/pulse_cal_pkg.sv
// types for the pulse generator calibration unit
package pulse_cal_pkg;
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ARM,
		ST_MEASURE,
		ST_DECIDE,
		ST_FINISH
	} cal_state_e;
endpackage

// file: logic/pulse_sync3.sv
// three-stage synchroniser with agreement filter for a pulse pin
`timescale 1ns/10ps
module pulse_sync3 (
	// clock and reset
	input  wire logic sys_clk_in,
	input  wire logic arst_n_in,
	// pin side
	input  wire logic async_in,
	// filtered level and rising edge
	output logic      level_out,
	output logic      rise_out
);
	logic [2:0] stage_r;
	logic       level_r;

	always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			stage_r <= 3'h0;
		end else begin
			stage_r <= {stage_r[1:0], async_in};
		end
	end

	// change accepted once second and third stages agree
	always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			level_r <= 1'b0;
		end else if (stage_r[1] == stage_r[2]) begin
			level_r <= stage_r[2];
		end
	end

	assign level_out = level_r;
	assign rise_out  = (stage_r[1] == stage_r[2]) && stage_r[2] && !level_r;
endmodule

// file: testbench/test_pulse_gen_bandwidth_cal.sv
// self-checking bench for the pulse generator calibration unit
`timescale 1ns/10ps
`include "pulse_cal_regs.svh"

module test_pulse_gen_bandwidth_cal;
	logic        sys_clk_in = 1'b0;
	logic        arst_n_in = 1'b0;
	logic [7:0]  avs_address_in = 8'h00;
	logic        avs_read_in = 1'b0;
	logic        avs_write_in = 1'b0;
	logic [31:0] avs_writedata_in = 32'h0;
	logic [3:0]  avs_byteenable_in = 4'hF;
	logic [31:0] avs_readdata_out;
	logic        avs_waitrequest_out;
	logic        pulse_in = 1'b0;
	logic [7:0]  pulse_spacing_delay_out;
	logic        cw_mode_out;
	logic        irq_out;
	logic [5:0]  pcnt = 6'h00;
	logic [5:0]  per_r = 6'h16;
	logic [31:0] rd;
	integer      n_errors = 0;
	integer      tests_run = 0;
	integer      seed = 97;

	pulse_gen_bandwidth_cal dut_u (
		.sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in),
		.avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
		.avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
		.avs_byteenable_in(avs_byteenable_in), .avs_readdata_out(avs_readdata_out),
		.avs_waitrequest_out(avs_waitrequest_out), .pulse_in(pulse_in),
		.pulse_spacing_delay_out(pulse_spacing_delay_out), .cw_mode_out(cw_mode_out),
		.irq_out(irq_out)
	);

	always #4 sys_clk_in = ~sys_clk_in;

	// ----------------------------------------
	// generator: spacing follows the delay
	// ----------------------------------------
	always @(negedge sys_clk_in) per_r <= 6'h06 + {1'b0, pulse_spacing_delay_out[7:3]};
	always @(posedge sys_clk_in) begin
		if (pcnt >= per_r - 6'h01) pcnt <= 6'h00;
		else pcnt <= pcnt + 6'h01;
		pulse_in <= (pcnt < 6'h03);
	end

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic wrap_up();
		if (n_errors == 0 && tests_run > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run = tests_run + 1;
		if (got !== exp) begin
			n_errors = n_errors + 1;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk_rng(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
		tests_run = tests_run + 1;
		if ((got >= lo && got <= hi) !== 1'b1) begin
			n_errors = n_errors + 1;
			$display("FAIL t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
		end
	endtask

	task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
		logic ready;
		ready = 1'b0;
		@(posedge sys_clk_in);
		avs_address_in <= a;
		avs_writedata_in <= d;
		avs_write_in <= we;
		avs_read_in <= !we;
		// hold until waitrequest is seen low at a rising edge
		while (!ready) begin
			@(posedge sys_clk_in);
			ready = (avs_waitrequest_out === 1'b0);
		end
		rd = avs_readdata_out;
		avs_write_in <= 1'b0;
		avs_read_in <= 1'b0;
		chk(ready, 1'b1);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask

	task automatic rdr(input logic [7:0] a);
		bus(1'b0, a, 32'h0);
	endtask

	task automatic wait_clear(input integer b);
		integer k;
		k = 0;
		rdr(`CTRL_OFFSET);
		while (rd[b] !== 1'b0 && k < 600) begin
			repeat (30) @(posedge sys_clk_in);
			rdr(`CTRL_OFFSET);
			k = k + 1;
		end
		chk(rd[b], 1'b0);
	endtask

	function automatic integer exp_cnt(input integer w, input logic [7:0] d);
		return (w * 64 + 64) / (6 + d[7:3]);
	endfunction

	function automatic integer best_gap(input integer t);
		integer p;
		integer e;
		integer g;
		g = 4096;
		for (p = 6; p < 38; p++) begin
			e = 1024 / p - t;
			if (e < 0) e = -e;
			if (e < g) g = e;
		end
		return g;
	endfunction

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		integer      i;
		integer      w;
		integer      e;
		integer      t;
		integer      g;
		logic [7:0]  d;
		logic [15:0] v;
		logic [11:0] c;
		logic [11:0] cnt [0:1];
		repeat (10) @(posedge sys_clk_in);
		arst_n_in <= 1'b1;
		rdr(`STATUS_OFFSET); chk(rd, 32'h0);
		rdr(`TEST_OFFSET); chk(rd, 32'h0);
		rdr(`TARGET_OFFSET); chk(rd, 32'h000000A6);
		rdr(`CTRL_OFFSET); chk(rd, 32'h00000080);
		rdr(8'h30); chk(rd, 32'h0);
		chk(cw_mode_out, 1'b0);
		chk(pulse_spacing_delay_out, 8'h80);
		chk(irq_out, 1'b0);
		wr(`STATUS_OFFSET, 32'h00001FFF);
		rdr(`STATUS_OFFSET); chk(rd, 32'h0);
		for (i = 0; i < 4; i++) begin
			v = (i == 0) ? 16'h000F : (i == 3) ? 16'h0000 : 16'($random(seed));
			wr(`TEST_OFFSET, {16'h0, v});
			@(negedge sys_clk_in);
			chk(cw_mode_out, v == 16'h000F);
			rdr(`TEST_OFFSET); chk(rd, {16'h0, v});
		end
		wr(`IRQ_MASK_OFFSET, 32'h1);
		for (i = 0; i < 4; i++) begin
			d = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($random(seed));
			w = (i < 2) ? 15 : 8 + ($random(seed) & 7);
			e = exp_cnt(w, d);
			wr(`TXCTRL_OFFSET, {24'h0, d});
			@(negedge sys_clk_in);
			chk(pulse_spacing_delay_out, d);
			wr(`CTRL_OFFSET, 32'(w << 2) | 32'h81);
			wait_clear(`CTRL_COUNT_BIT);
			rdr(`STATUS_OFFSET);
			chk_rng(rd[11:0], e - 1, e + 1);
			chk(rd[12], 1'b0);
			if (i < 2) cnt[i] = rd[11:0];
			@(negedge sys_clk_in);
			chk(irq_out, 1'b1);
			wr(`IRQ_STAT_OFFSET, 32'h1);
			@(negedge sys_clk_in);
			chk(irq_out, 1'b0);
		end
		chk(cnt[0] > cnt[1], 1'b1);
		for (i = 0; i < 2; i++) begin
			t = 40 + ($random(seed) & 63);
			g = best_gap(t);
			wr(`IRQ_MASK_OFFSET, (i == 0) ? 32'h2 : 32'h0);
			wr(`TARGET_OFFSET, 32'(t));
			wr(`CTRL_OFFSET, 32'h000000BE);
			rdr(`STATUS_OFFSET); chk(rd[12], 1'b0);
			wait_clear(`CTRL_AUTO_BIT);
			rdr(`STATUS_OFFSET); chk(rd[12], 1'b1);
			chk_rng(rd[11:0], t - g - 3, t + g + 3);
			c = rd[11:0];
			rdr(`TXCTRL_OFFSET); chk(pulse_spacing_delay_out, rd[7:0]);
			e = exp_cnt(15, rd[7:0]);
			chk_rng(c, e - 1, e + 1);
			@(negedge sys_clk_in);
			chk(irq_out, i == 0);
			rdr(`IRQ_STAT_OFFSET); chk(rd[1], 1'b1);
			wr(`IRQ_STAT_OFFSET, 32'h2);
			rdr(`IRQ_STAT_OFFSET); chk(rd[1], 1'b0);
		end
		wrap_up();
	end

	initial begin
		repeat (60000) @(posedge sys_clk_in);
		n_errors = n_errors + 1;
		wrap_up();
	end
endmodule
